/* File: design/hspg_defs.svh */
// Purpose: offsets, field positions, reset values and sizes of the sync pattern generator
// Assumes: 8-bit subaddress space reached over the two-wire slave port
// Notes:   definitions only
`ifndef HSPG_DEFS_SVH
`define HSPG_DEFS_SVH

`define HSPG_I2C_ADDR    7'h44
`define HSPG_SUB_SEQ     8'hD0
`define HSPG_SUB_LT      8'hD1
`define HSPG_SUB_PAT     8'hD2
`define HSPG_SUB_VAL     8'hD3
`define HSPG_SUB_WID_L   8'hD4
`define HSPG_SUB_WID_H   8'hD5
`define HSPG_SUB_HGT_L   8'hD6
`define HSPG_SUB_HGT_H   8'hD7
`define HSPG_SUB_TRX_L   8'hD8
`define HSPG_SUB_TRX_H   8'hD9
`define HSPG_SUB_TRY_L   8'hDA
`define HSPG_SUB_TRY_H   8'hDB
`define HSPG_SUB_CTRL    8'hDC
`define HSPG_SUB_STAT    8'hDD

`define HSPG_SEQ_BYTES   7'd32
`define HSPG_LT_BYTES    7'd60
`define HSPG_PAT_BYTES   7'd56
`define HSPG_VAL_BYTES   7'd16

`define HSPG_CTRL_INS    0
`define HSPG_CTRL_GAIN   1
`define HSPG_CTRL_RST    8'h00
`define HSPG_DIM_RST     12'h000
`define HSPG_GAIN_NUM    18'h000B1

`endif

/* File: design/hspg_pkg.sv */
// Purpose: state types of the sync pattern generator
// Assumes: one packed state struct per module
// Notes:   constants live in hspg_defs.svh
package hspg_pkg;

    typedef enum logic [6:0] {
        HSPG_I_IDLE  = 7'h01,
        HSPG_I_ADDR  = 7'h02,
        HSPG_I_ACK_A = 7'h04,
        HSPG_I_WDATA = 7'h08,
        HSPG_I_ACK_W = 7'h10,
        HSPG_I_RDATA = 7'h20,
        HSPG_I_ACK_R = 7'h40
    } hspg_i2c_state_t;

    typedef struct packed {
        hspg_i2c_state_t state;
        logic [2:0]      scl_sync;
        logic [2:0]      sda_sync;
        logic            scl_f;
        logic            sda_f;
        logic [2:0]      cnt;
        logic            got8;
        logic [7:0]      sh;
        logic            rw;
        logic            first;
        logic            sda_oe;
        logic            wr;
        logic            rd;
        logic [7:0]      wdata;
    } hspg_i2c_t;

    typedef struct packed {
        logic [31:0][7:0] seq_mem;
        logic [59:0][7:0] lt_mem;
        logic [55:0][7:0] pat_mem;
        logic [15:0][7:0] val_mem;
        logic [7:0]       sub;
        logic             ptr_wait;
        logic [6:0]       tbl_addr;
        logic [11:0]      wid;
        logic [11:0]      hgt;
        logic [11:0]      tx;
        logic [11:0]      ty;
        logic [7:0]       ctrl;
        logic [11:0]      x;
        logic [11:0]      y;
        logic             run;
        logic [3:0]       seq_idx;
        logic [9:0]       line_left;
        logic [2:0]       slot;
        logic [1:0]       pair;
        logic [11:0]      dur;
        logic [7:0]       lvl_prev;
        logic [7:0]       out_r;
        logic [7:0]       out_g;
        logic [7:0]       out_b;
        logic             hs;
        logic             vs;
    } hspg_gen_t;

endpackage : hspg_pkg

/* File: design/hspg_i2c_slave.sv */
// Purpose: two-wire slave byte engine with subaddress framing
// Assumes: clk far faster than the serial clock; pins synchronised here
// Notes:   sda is open drain, sda_oe high pulls the line low
`timescale 1ns/100ps
`include "hspg_defs.svh"
module hspg_i2c_slave
    import hspg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            bus_wr,
    output logic            bus_first,
    output logic [7:0]      bus_wdata,
    output logic            bus_rd,
    input  wire logic [7:0] bus_rdata
);

    hspg_i2c_t st_reg;
    hspg_i2c_t st_next;

    always_comb begin
        logic scl_n;
        logic sda_n;
        logic rise;
        logic fall;
        logic start;
        logic stop;
        st_next = st_reg;
        st_next.scl_sync = {st_reg.scl_sync[1:0], scl_in};
        st_next.sda_sync = {st_reg.sda_sync[1:0], sda_in};
        // a change counts only once stages two and three agree
        scl_n = (st_reg.scl_sync[2] == st_reg.scl_sync[1]) ? st_reg.scl_sync[1] : st_reg.scl_f;
        sda_n = (st_reg.sda_sync[2] == st_reg.sda_sync[1]) ? st_reg.sda_sync[1] : st_reg.sda_f;
        st_next.scl_f = scl_n;
        st_next.sda_f = sda_n;
        rise  = scl_n & ~st_reg.scl_f;
        fall  = ~scl_n & st_reg.scl_f;
        start = scl_n & st_reg.scl_f & st_reg.sda_f & ~sda_n;
        stop  = scl_n & st_reg.scl_f & ~st_reg.sda_f & sda_n;
        st_next.wr = 1'b0;
        st_next.rd = 1'b0;
        if (start) begin
            st_next.state  = HSPG_I_ADDR;
            st_next.cnt    = 3'd0;
            st_next.got8   = 1'b0;
            st_next.first  = 1'b1;
            st_next.sda_oe = 1'b0;
        end else if (stop) begin
            st_next.state  = HSPG_I_IDLE;
            st_next.sda_oe = 1'b0;
        end else begin
            case (st_reg.state)
                HSPG_I_IDLE: begin
                    st_next.sda_oe = 1'b0;
                end
                HSPG_I_ADDR, HSPG_I_WDATA: begin
                    if (rise) begin
                        st_next.sh   = {st_reg.sh[6:0], sda_n};
                        st_next.cnt  = st_reg.cnt + 3'd1;
                        st_next.got8 = (st_reg.cnt == 3'd7);
                    end else if (fall && st_reg.got8) begin
                        st_next.got8 = 1'b0;
                        if (st_reg.state == HSPG_I_ADDR) begin
                            if (st_reg.sh[7:1] == `HSPG_I2C_ADDR) begin
                                st_next.state  = HSPG_I_ACK_A;
                                st_next.rw     = st_reg.sh[0];
                                st_next.sda_oe = 1'b1;
                            end else begin
                                st_next.state = HSPG_I_IDLE;
                            end
                        end else begin
                            st_next.wr     = 1'b1;
                            st_next.wdata  = st_reg.sh;
                            st_next.state  = HSPG_I_ACK_W;
                            st_next.sda_oe = 1'b1;
                        end
                    end
                end
                HSPG_I_ACK_A: begin
                    if (fall) begin
                        st_next.cnt = 3'd0;
                        if (st_reg.rw) begin
                            st_next.state  = HSPG_I_RDATA;
                            st_next.rd     = 1'b1;
                            st_next.sh     = bus_rdata;
                            st_next.sda_oe = ~bus_rdata[7];
                        end else begin
                            st_next.state  = HSPG_I_WDATA;
                            st_next.sda_oe = 1'b0;
                        end
                    end
                end
                HSPG_I_ACK_W: begin
                    if (fall) begin
                        // first must still stand while its own write strobe is up
                        st_next.first  = 1'b0;
                        st_next.state  = HSPG_I_WDATA;
                        st_next.sda_oe = 1'b0;
                    end
                end
                HSPG_I_RDATA: begin
                    if (rise) begin
                        st_next.cnt  = st_reg.cnt + 3'd1;
                        st_next.got8 = (st_reg.cnt == 3'd7);
                    end else if (fall) begin
                        if (st_reg.got8) begin
                            st_next.got8   = 1'b0;
                            st_next.sda_oe = 1'b0;
                            st_next.state  = HSPG_I_ACK_R;
                        end else begin
                            st_next.sh     = {st_reg.sh[6:0], 1'b0};
                            st_next.sda_oe = ~st_reg.sh[6];
                        end
                    end
                end
                HSPG_I_ACK_R: begin
                    // master nack ends the read burst
                    if (rise && sda_n) begin
                        st_next.state = HSPG_I_IDLE;
                    end else if (fall) begin
                        st_next.state  = HSPG_I_RDATA;
                        st_next.cnt    = 3'd0;
                        st_next.rd     = 1'b1;
                        st_next.sh     = bus_rdata;
                        st_next.sda_oe = ~bus_rdata[7];
                    end
                end
                default: begin
                    st_next.state  = HSPG_I_IDLE;
                    st_next.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg       <= '0;
            st_reg.state <= HSPG_I_IDLE;
            st_reg.scl_f <= 1'b1;
            st_reg.sda_f <= 1'b1;
            // idle bus level, so no false edge follows reset
            st_reg.scl_sync <= 3'h7;
            st_reg.sda_sync <= 3'h7;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sda_out   = 1'b0;
    assign sda_oe    = st_reg.sda_oe;
    assign bus_wr    = st_reg.wr;
    assign bus_first = st_reg.first;
    assign bus_wdata = st_reg.wdata;
    assign bus_rd    = st_next.rd;

endmodule : hspg_i2c_slave

/* File: design/hspg_sync_gen.sv */
// Purpose: table driven sync raster engine for the high definition output path
// Assumes: clk is the pixel clock; tables written over the two-wire slave port
// Notes:   video in and level inserted out are 8 bits per channel
`timescale 1ns/100ps
`include "hspg_defs.svh"
module hspg_sync_gen
    import hspg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [7:0] pix_r,
    input  wire logic [7:0] pix_g,
    input  wire logic [7:0] pix_b,
    output logic [7:0]      dac_r,
    output logic [7:0]      dac_g,
    output logic [7:0]      dac_b,
    output logic            digital_hsync_composite_out,
    output logic            digital_vsync_out
);

    hspg_gen_t  st_reg;
    hspg_gen_t  st_next;
    logic       bus_wr;
    logic       bus_first;
    logic [7:0] bus_wdata;
    logic       bus_rd;
    logic [7:0] bus_rdata;
    logic       tbl_sel;

    hspg_i2c_slave u_i2c (
        .clk       (clk),
        .rst_b     (rst_b),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .sda_out   (sda_out),
        .sda_oe    (sda_oe),
        .bus_wr    (bus_wr),
        .bus_first (bus_first),
        .bus_wdata (bus_wdata),
        .bus_rd    (bus_rd),
        .bus_rdata (bus_rdata)
    );

    function automatic logic [15:0] seq_ent(input logic [3:0] i);
        seq_ent = {st_reg.seq_mem[{i, 1'b1}], st_reg.seq_mem[{i, 1'b0}]};
    endfunction : seq_ent

    function automatic logic [3:0] lt_nib(input logic [3:0] t, input logic [2:0] s);
        logic [7:0] b;
        b = 8'h00;
        if (t != 4'h0) begin
            b = st_reg.lt_mem[{4'(t - 4'h1), s[2:1]}];
        end
        lt_nib = s[0] ? b[7:4] : b[3:0];
    endfunction : lt_nib

    function automatic logic [15:0] pat_pair(input logic [3:0] p, input logic [1:0] q);
        pat_pair = 16'h0000;
        if (p != 4'h0 && p < 4'h8) begin
            pat_pair = {st_reg.pat_mem[{3'(p - 4'h1), q, 1'b1}],
                        st_reg.pat_mem[{3'(p - 4'h1), q, 1'b0}]};
        end
    endfunction : pat_pair

    function automatic logic [11:0] pat_dur(input logic [3:0] p);
        logic [15:0] w;
        w       = pat_pair(p, 2'd0);
        pat_dur = w[11:0];
    endfunction : pat_dur

    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[8] ? 8'hFF : s[7:0];
    endfunction : sat_add

    function automatic logic [7:0] scale(input logic [7:0] v, input logic en);
        logic [17:0] p;
        p = 18'(v) * `HSPG_GAIN_NUM;
        scale = en ? p[15:8] : v;
    endfunction : scale

    assign tbl_sel = (st_reg.sub >= `HSPG_SUB_SEQ) && (st_reg.sub <= `HSPG_SUB_VAL);

    always_comb begin
        case (st_reg.sub)
            `HSPG_SUB_SEQ:   bus_rdata = (st_reg.tbl_addr < `HSPG_SEQ_BYTES) ?
                                         st_reg.seq_mem[st_reg.tbl_addr[4:0]] : 8'h00;
            `HSPG_SUB_LT:    bus_rdata = (st_reg.tbl_addr < `HSPG_LT_BYTES) ?
                                         st_reg.lt_mem[st_reg.tbl_addr[5:0]] : 8'h00;
            `HSPG_SUB_PAT:   bus_rdata = (st_reg.tbl_addr < `HSPG_PAT_BYTES) ?
                                         st_reg.pat_mem[st_reg.tbl_addr[5:0]] : 8'h00;
            `HSPG_SUB_VAL:   bus_rdata = (st_reg.tbl_addr < `HSPG_VAL_BYTES) ?
                                         st_reg.val_mem[st_reg.tbl_addr[3:0]] : 8'h00;
            `HSPG_SUB_WID_L: bus_rdata = st_reg.wid[7:0];
            `HSPG_SUB_WID_H: bus_rdata = {4'h0, st_reg.wid[11:8]};
            `HSPG_SUB_HGT_L: bus_rdata = st_reg.hgt[7:0];
            `HSPG_SUB_HGT_H: bus_rdata = {4'h0, st_reg.hgt[11:8]};
            `HSPG_SUB_TRX_L: bus_rdata = st_reg.tx[7:0];
            `HSPG_SUB_TRX_H: bus_rdata = {4'h0, st_reg.tx[11:8]};
            `HSPG_SUB_TRY_L: bus_rdata = st_reg.ty[7:0];
            `HSPG_SUB_TRY_H: bus_rdata = {4'h0, st_reg.ty[11:8]};
            `HSPG_SUB_CTRL:  bus_rdata = st_reg.ctrl;
            `HSPG_SUB_STAT:  bus_rdata = {st_reg.run, 3'h0, st_reg.seq_idx};
            default:         bus_rdata = 8'h00;
        endcase
    end

    always_comb begin
        logic [15:0] se;
        logic [3:0]  cur_type;
        logic [3:0]  pidx;
        logic [15:0] pw;
        logic [15:0] pw_nx;
        logic [3:0]  nib_nx;
        logic [3:0]  nidx;
        logic [15:0] nse;
        logic [7:0]  lvl;
        logic [1:0]  route;
        logic [8:0]  lsum;
        logic [7:0]  lvl_f;
        logic        trig;
        logic [6:0]  a;
        st_next = st_reg;
        a = st_reg.tbl_addr;

        if (bus_wr) begin
            if (bus_first) begin
                st_next.sub      = bus_wdata;
                st_next.ptr_wait = 1'b1;
            end else if (tbl_sel) begin
                if (st_reg.ptr_wait) begin
                    st_next.ptr_wait = 1'b0;
                    case (st_reg.sub)
                        `HSPG_SUB_LT:  st_next.tbl_addr = {bus_wdata[4:0], 2'b00};
                        `HSPG_SUB_PAT: st_next.tbl_addr = {bus_wdata[3:0], 3'b000};
                        default:       st_next.tbl_addr = {bus_wdata[5:0], 1'b0};
                    endcase
                end else begin
                    case (st_reg.sub)
                        `HSPG_SUB_SEQ: if (a < `HSPG_SEQ_BYTES) st_next.seq_mem[a[4:0]] = bus_wdata;
                        `HSPG_SUB_LT:  if (a < `HSPG_LT_BYTES) st_next.lt_mem[a[5:0]] = bus_wdata;
                        `HSPG_SUB_PAT: if (a < `HSPG_PAT_BYTES) st_next.pat_mem[a[5:0]] = bus_wdata;
                        default:       if (a < `HSPG_VAL_BYTES) st_next.val_mem[a[3:0]] = bus_wdata;
                    endcase
                    st_next.tbl_addr = a + 7'd1;
                end
            end else begin
                case (st_reg.sub)
                    `HSPG_SUB_WID_L: st_next.wid[7:0]  = bus_wdata;
                    `HSPG_SUB_WID_H: st_next.wid[11:8] = bus_wdata[3:0];
                    `HSPG_SUB_HGT_L: st_next.hgt[7:0]  = bus_wdata;
                    `HSPG_SUB_HGT_H: st_next.hgt[11:8] = bus_wdata[3:0];
                    `HSPG_SUB_TRX_L: st_next.tx[7:0]   = bus_wdata;
                    `HSPG_SUB_TRX_H: st_next.tx[11:8]  = bus_wdata[3:0];
                    `HSPG_SUB_TRY_L: st_next.ty[7:0]   = bus_wdata;
                    `HSPG_SUB_TRY_H: st_next.ty[11:8]  = bus_wdata[3:0];
                    `HSPG_SUB_CTRL:  st_next.ctrl      = bus_wdata;
                    default:         st_next.ctrl      = st_reg.ctrl;
                endcase
                st_next.sub = st_reg.sub + 8'h01;
            end
        end else if (bus_rd) begin
            // table reads walk the same pointer that writes use
            if (tbl_sel) begin
                st_next.tbl_addr = a + 7'd1;
            end else begin
                st_next.sub = st_reg.sub + 8'h01;
            end
        end

        // raster counter and trigger
        trig = (st_reg.x == st_reg.tx) && (st_reg.y == st_reg.ty);
        if (st_reg.x == 12'(st_reg.wid - 12'd1)) begin
            st_next.x = 12'd0;
            st_next.y = (st_reg.y == 12'(st_reg.hgt - 12'd1)) ? 12'd0 : st_reg.y + 12'd1;
        end else begin
            st_next.x = st_reg.x + 12'd1;
        end

        se       = seq_ent(st_reg.seq_idx);
        cur_type = se[15:12];
        pidx     = lt_nib(cur_type, st_reg.slot);
        pw       = pat_pair(pidx, st_reg.pair);
        pw_nx    = pat_pair(pidx, 2'(st_reg.pair + 2'd1));
        nib_nx   = lt_nib(cur_type, 3'(st_reg.slot + 3'd1));
        nidx     = 4'h0;
        nse      = 16'h0000;

        if (trig) begin
            nse               = seq_ent(4'h0);
            st_next.run       = 1'b1;
            st_next.seq_idx   = 4'h0;
            st_next.line_left = (nse[9:0] == 10'd0) ? 10'd0 : nse[9:0] - 10'd1;
            st_next.slot      = 3'd0;
            st_next.pair      = 2'd0;
            st_next.dur       = pat_dur(lt_nib(nse[15:12], 3'd0));
        end else if (st_reg.run) begin
            if (st_reg.dur != 12'd0) begin
                st_next.dur = st_reg.dur - 12'd1;
            end else if (st_reg.pair != 2'd3 && pw_nx != 16'h0000) begin
                st_next.pair = st_reg.pair + 2'd1;
                st_next.dur  = {pw_nx[11:8], pw_nx[7:0]};
            end else if (st_reg.slot != 3'd7 && nib_nx != 4'h0) begin
                st_next.slot = st_reg.slot + 3'd1;
                st_next.pair = 2'd0;
                st_next.dur  = pat_dur(nib_nx);
            end else begin
                st_next.slot = 3'd0;
                st_next.pair = 2'd0;
                if (st_reg.line_left != 10'd0) begin
                    st_next.line_left = st_reg.line_left - 10'd1;
                    st_next.dur       = pat_dur(lt_nib(cur_type, 3'd0));
                end else begin
                    nidx = st_reg.seq_idx + 4'h1;
                    nse  = seq_ent(nidx);
                    if (st_reg.seq_idx == 4'hF || nse[15:12] == 4'h0) begin
                        nidx = 4'h0;
                        nse  = seq_ent(nidx);
                    end
                    st_next.seq_idx   = nidx;
                    st_next.line_left = (nse[9:0] == 10'd0) ? 10'd0 : nse[9:0] - 10'd1;
                    st_next.dur       = pat_dur(lt_nib(nse[15:12], 3'd0));
                end
            end
        end

        // level of the running segment; empty pair means nothing inserted
        lvl   = 8'h00;
        route = 2'b00;
        if (st_reg.run && pw != 16'h0000) begin
            lvl   = st_reg.val_mem[{pw[14:12], 1'b0}];
            route = st_reg.val_mem[{pw[14:12], 1'b1}][1:0];
        end
        // two tap average keeps steps off the analog reconstruction filter
        lsum             = {1'b0, lvl} + {1'b0, st_reg.lvl_prev};
        lvl_f            = lsum[8:1];
        st_next.lvl_prev = lvl;

        if (st_reg.ctrl[`HSPG_CTRL_INS] && st_reg.run) begin
            st_next.out_g = sat_add(scale(pix_g, st_reg.ctrl[`HSPG_CTRL_GAIN]), lvl_f);
            st_next.out_r = scale(pix_r, st_reg.ctrl[`HSPG_CTRL_GAIN]);
            st_next.out_b = scale(pix_b, st_reg.ctrl[`HSPG_CTRL_GAIN]);
            if (!pw[15]) begin
                st_next.out_r = sat_add(st_next.out_r, lvl_f);
                st_next.out_b = sat_add(st_next.out_b, lvl_f);
            end
        end else begin
            st_next.out_r = pix_r;
            st_next.out_g = pix_g;
            st_next.out_b = pix_b;
        end
        st_next.hs = route[0];
        st_next.vs = route[1];
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg      <= '0;
            st_reg.ctrl <= `HSPG_CTRL_RST;
            st_reg.wid  <= `HSPG_DIM_RST;
            st_reg.hgt  <= `HSPG_DIM_RST;
            st_reg.sub  <= `HSPG_SUB_SEQ;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dac_r                       = st_reg.out_r;
    assign dac_g                       = st_reg.out_g;
    assign dac_b                       = st_reg.out_b;
    assign digital_hsync_composite_out = st_reg.hs;
    assign digital_vsync_out           = st_reg.vs;

endmodule : hspg_sync_gen

/* File: sim/hspg_sync_checker.sv */
// Purpose: port level checks of the sync generator
// Assumes: one pixel clock domain
// Notes:   bound to every generator instance below
`timescale 1ns/100ps
module hspg_sync_checker (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [7:0] pix_g,
    input wire logic [7:0] dac_g,
    input wire logic [7:0] dac_r,
    input wire logic       digital_hsync_composite_out,
    input wire logic       digital_vsync_out
);
    default clocking @(posedge clk); endclocking
    wire logic sy = digital_hsync_composite_out | digital_vsync_out;
    dac_clear_a: assert property (!rst_b |=> dac_g == 8'h00 && dac_r == 8'h00)
        else $error("dac not cleared");
    sync_clear_a: assert property (!rst_b |=> !sy)
        else $error("sync not cleared");
    ack_clear_a: assert property (!rst_b |=> !sda_oe)
        else $error("ack not cleared");
    sda_low_a: assert property (sda_out == 1'b0)
        else $error("sda value high");
    ack_rise_a: assert property (disable iff (!rst_b) $rose(sda_oe) |-> !scl_in)
        else $error("ack rose in clock high");
    ack_fall_a: assert property (disable iff (!rst_b) $fell(sda_oe) |-> !scl_in)
        else $error("ack fell in clock high");
    sync_quiet_a: assert property ($rose(rst_b) |-> (!sy)[*4])
        else $error("sync with empty tables");
    pass_thru_a: assert property ($rose(rst_b) |=> dac_g == $past(pix_g))
        else $error("video not passed");
endmodule : hspg_sync_checker
bind hspg_sync_gen hspg_sync_checker i_chk (.clk, .rst_b, .scl_in, .sda_out, .sda_oe, .pix_g,
    .dac_g, .dac_r, .digital_hsync_composite_out, .digital_vsync_out);

/* File: sim/hspg_dac_sink.sv */
// Purpose: converter side stand-in counting sync and level samples
// Assumes: same pixel clock as the generator
// Notes:   counts restart while clr is high
`timescale 1ns/100ps
module hspg_dac_sink (
    input  wire logic       clk,
    input  wire logic       clr,
    input  wire logic       hs,
    input  wire logic       vs,
    input  wire logic [7:0] lvl,
    output int              hs_cnt,
    output int              vs_cnt,
    output int              mid_cnt,
    output int              top_cnt
);
    always @(posedge clk) begin
        hs_cnt  <= clr ? 0 : hs_cnt + int'(hs === 1'b1);
        vs_cnt  <= clr ? 0 : vs_cnt + int'(vs === 1'b1);
        mid_cnt <= clr ? 0 : mid_cnt + int'(lvl === 8'h20);
        top_cnt <= clr ? 0 : top_cnt + int'(lvl === 8'h40);
    end
endmodule : hspg_dac_sink

/* File: sim/tb_hd_sync_pattern_generator.sv */
// Purpose: directed run of the sync generator over its serial port
// Assumes: 20 MHz pixel clock; serial bit of 24 clocks
// Notes:   one line is 12 clocks, a frame two lines
`timescale 1ns/100ps
module tb_hd_sync_pattern_generator;
    logic       clk = 1'b0, rst_b = 1'b0, scl_in = 1'b1, sda_m = 1'b1, clr = 1'b1;
    logic [7:0] pix_r = 8'h00, pix_g = 8'h00, pix_b = 8'h00;
    wire logic  sda_out, sda_oe, digital_hsync_composite_out, digital_vsync_out;
    wire logic  [7:0] dac_r, dac_g, dac_b;
    wire logic  sda_in = sda_m & ~sda_oe;
    int         miscompares = 0, samples_checked = 0, cyc = 0, hs_cnt, vs_cnt, mid_cnt, top_cnt;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    hspg_sync_gen i_dut (.clk, .rst_b, .scl_in, .sda_in, .sda_out, .sda_oe, .pix_r, .pix_g,
        .pix_b, .dac_r, .dac_g, .dac_b, .digital_hsync_composite_out, .digital_vsync_out);
    hspg_dac_sink i_sink (.clk, .clr, .hs(digital_hsync_composite_out), .vs(digital_vsync_out),
        .lvl(dac_r), .hs_cnt, .vs_cnt, .mid_cnt, .top_cnt);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic hp();
        repeat (8) @(posedge clk);
    endtask : hp
    task automatic sbit(input logic b, input logic ack);
        hp();
        sda_m  <= b;
        hp();
        scl_in <= 1'b1;
        hp();
        if (ack) chk(32'(sda_oe), 32'h1);
        scl_in <= 1'b0;
    endtask : sbit
    task automatic st();
        @(posedge clk);
        sda_m <= 1'b0;
        hp();
        scl_in <= 1'b0;
    endtask : st
    task automatic sp();
        hp();
        sda_m  <= 1'b0;
        hp();
        scl_in <= 1'b1;
        hp();
        sda_m  <= 1'b1;
        hp();
    endtask : sp
    task automatic wr(input logic [7:0] d[$]);
        d.push_front(8'h88);
        st();
        foreach (d[i]) begin
            for (int k = 7; k >= 0; k--) sbit(d[i][k], 1'b0);
            sbit(1'b1, 1'b1);
        end
        sp();
    endtask : wr
    task automatic rd(input logic [7:0] exp);
        logic [7:0] got;
        logic [7:0] adr;
        got = 8'h00;
        adr = 8'h89;
        st();
        for (int k = 7; k >= 0; k--) sbit(adr[k], 1'b0);
        sbit(1'b1, 1'b1);
        for (int k = 7; k >= 0; k--) begin
            sbit(1'b1, 1'b0);
            got[k] = sda_in;
        end
        sbit(1'b1, 1'b0);
        sp();
        chk(32'(got), 32'(exp));
    endtask : rd
    task automatic measure(input int hs, input int vs, input int mid, input int top);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (120) @(posedge clk);
        @(negedge clk);
        chk(hs_cnt, hs);
        chk(vs_cnt, vs);
        chk(mid_cnt, mid);
        chk(top_cnt, top);
    endtask : measure
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        wr({8'hD4, 8'h0C, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        wr({8'hD3, 8'h00, 8'h00, 8'h00, 8'h40, 8'h01, 8'h00, 8'h02});
        wr({8'hD2, 8'h00, 8'h03, 8'h10, 8'h07, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00});
        wr({8'hD3, 8'h01});
        rd(8'h40);
        wr({8'hD1, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00});
        wr({8'hD0, 8'h00, 8'h01, 8'h10, 8'h01, 8'h10});
        pix_r <= 8'h5A;
        repeat (2) @(negedge clk);
        chk(32'(dac_r), 32'h5A);
        measure(40, 80, 0, 0);
        @(posedge clk);
        pix_r <= 8'h00;
        wr({8'hDC, 8'h0B});
        measure(40, 80, 20, 30);
        wr({8'hDC});
        rd(8'h0B);
        print_verdict();
    end
endmodule : tb_hd_sync_pattern_generator
